// *** dd_chan.sv ***
// One converter channel: input, converter and readback registers
`timescale 1ns/1ps
module dd_chan import dd_pkg::*; #(
  parameter int RES_BITS = 12
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                commit,
  input  wire logic                sel,
  input  wire dd_word_t            word,
  output logic      [RES_BITS-1:0] dac_code,
  output logic      [1:0]          pd_mode,
  output dd_word_t                 rd_word
);

  // ========================================================================
  // Channel state
  logic [RES_BITS-1:0] in_code;
  logic                updated;
  logic [RES_BITS-1:0] next_in_code;
  logic [RES_BITS-1:0] next_dac_code;
  logic                next_updated;
  logic [1:0]          next_pd_mode;
  dd_word_t            next_rd_word;
  logic [RES_BITS-1:0] wcode;
  dd_word_t            masked;

  // Left-justified code; unused low bits read back as zero
  assign wcode  = word.code[CODE_FIELD-1 -: RES_BITS];
  always_comb begin
    masked      = word;
    masked.code = '0;
    masked.code[CODE_FIELD-1 -: RES_BITS] = wcode;
  end

  // Update on a completed word; clear beats load
  always_comb begin
    next_in_code  = in_code;
    next_dac_code = dac_code;
    next_updated  = updated;
    next_pd_mode  = pd_mode;
    next_rd_word  = rd_word;
    if (commit && !word.clear_all_n) begin
      next_in_code  = '0;
      next_dac_code = '0;
      next_updated  = 1'b0;
      next_rd_word  = WORD_RESET;
    end else if (commit) begin
      if (sel) begin
        next_in_code = wcode;
        next_updated = 1'b1;
        next_pd_mode = word.pd;
        next_rd_word = masked;
      end
      // Only a channel written since the last load moves, to spare glitches
      if (!word.load_outputs_n && (sel || updated)) begin
        next_dac_code = sel ? wcode : in_code;
        next_updated  = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_code  <= '0;
      dac_code <= '0;
      updated  <= 1'b0;
      pd_mode  <= PD_NORMAL;
      rd_word  <= WORD_RESET;
    end else begin
      in_code  <= next_in_code;
      dac_code <= next_dac_code;
      updated  <= next_updated;
      pd_mode  <= next_pd_mode;
      rd_word  <= next_rd_word;
    end
  end

  // ========================================================================
  // Checks
  AST_CLEAR_ZERO: assert property (
    @(posedge clock) disable iff (sys_rst)
    commit && !word.clear_all_n |=> dac_code == '0 && in_code == '0)
    else $error("clear did not zero channel");
  AST_LOAD_HOLD: assert property (
    @(posedge clock) disable iff (sys_rst)
    commit && word.clear_all_n && word.load_outputs_n |=> $stable(dac_code))
    else $error("converter register moved without load");
  AST_RESET_ZERO: assert property (
    @(posedge clock) disable iff (sys_rst)
    $past(sys_rst) |-> dac_code == '0 && pd_mode == PD_NORMAL)
    else $error("channel not zero after reset");

endmodule

// *** dd_master.sv ***
// Behavioural two-wire bus master that drives the slave's bus pins
`timescale 1ns/1ps
module dd_master (
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl_line,
  output logic      sda_pull
);
  // ==========================================================
  // Bus idle: clock stands high, data released to the pull-up
  initial begin
    scl_line = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One clock pulse; data moves a cycle after the fall, never while high
  task automatic bit_io(input logic b, output logic r);
    scl_line <= 1'b0;
    tick(1);
    sda_pull <= ~b;
    tick(4);
    scl_line <= 1'b1;
    tick(2);
    r = sda_wire;
    tick(1);
  endtask

  // Start, or repeated start after releasing data in the low phase
  task automatic start(input logic rep);
    if (rep) begin
      scl_line <= 1'b0;
      tick(1);
      sda_pull <= 1'b0;
      tick(4);
      scl_line <= 1'b1;
      tick(4);
    end
    sda_pull <= 1'b1;
    tick(4);
  endtask

  // Stop: data low before the pulse, raised while clock is high
  task automatic stop();
    scl_line <= 1'b0;
    tick(1);
    sda_pull <= 1'b1;
    tick(4);
    scl_line <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(4);
  endtask

  // Eight bits first-to-last from the top, then the ninth for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Read a byte; ack high asks for more, low ends the read
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// *** dd_pkg.sv ***
// Package: constants, types and states of the dual converter two-wire slave
// ==========================================================================
// Notes on behaviour
// - Slave address is 000110 plus the address-select pin as its low bit.
// - Slave only; the serial clock is never driven, only sampled.
// - SDA falling while SCL high starts a new transaction.
// - On address match pull SDA low on ninth clock, else stay released.
// - Each byte is eight data clocks plus one acknowledge clock.
// - SDA changes only while SCL low, except start and stop.
// - Write is address, pointer, then data bytes, each acknowledged.
// - Pointer read uses repeated start then address with read direction.
// - Read without pointer byte uses the retained pointer settings.
// - Pointer bit 4 is format, bit 1 channel B, bit 0 channel A.
// - Format bit zero; data moves as two-byte words.
// - A set channel-select bit routes following data to that channel.
// - First data byte: two power-down bits, clear_n, load_n, top code bits.
// - After reset, normal mode and all registers hold zero.
// - Codes are straight binary, passed unchanged to the converter core.
// - Power-down bits: 00 normal, 01 1k, 10 100k, 11 high impedance.
// - Clear bit zero fills all input and converter registers with zero.
// - Load bit zero updates both converter registers; one updates input only.
// - Readback of none or both channels gives zeros with clear bit one.
package dd_pkg;

  // ========================================================================
  // Addressing and pointer layout
  localparam logic [5:0] ADDR_PREFIX   = 6'h06;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam int         PTR_FMT_BIT   = 4;
  localparam int         PTR_SEL_B_BIT = 1;
  localparam int         PTR_SEL_A_BIT = 0;

  // ========================================================================
  // Data word layout and values after reset
  localparam logic [15:0] READ_DEFAULT  = 16'h2000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  localparam int          CODE_FIELD    = 12;
  localparam int          SYNC_STAGES   = 2;

  // Power-down encodings
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K     = 2'h1;
  localparam logic [1:0] PD_100K   = 2'h2;
  localparam logic [1:0] PD_HIZ    = 2'h3;

  typedef struct packed {
    logic [1:0]            pd;
    logic                  clear_all_n;
    logic                  load_outputs_n;
    logic [CODE_FIELD-1:0] code;
  } dd_word_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_DATA, ST_DATA_ACK, ST_SEND, ST_SEND_ACK
  } dd_state_t;

endpackage

// *** dd_slave.sv ***
// Two-wire slave front end of a dual voltage-output converter
`timescale 1ns/1ps
module dd_slave import dd_pkg::*; #(
  parameter int RES_BITS = 12
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic                addr_select_pin,
  output logic      [RES_BITS-1:0] code_a,
  output logic      [RES_BITS-1:0] code_b,
  output logic      [1:0]          powerdown_a,
  output logic      [1:0]          powerdown_b
);

  // ========================================================================
  // Pin sampling and bus events
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       addr_sel_s;
  logic       scl_q;
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  // Clock line is only ever an input here
  dd_sync #(.W(3)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     ({scl_in, sda_in, addr_select_pin}),
    .dout    (pins_s)
  );
  assign scl_s      = pins_s[2];
  assign sda_s      = pins_s[1];
  assign addr_sel_s = pins_s[0];

  // Edge history taken from the synchronised copies
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Start and stop are SDA edges with SCL high
  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

  // ========================================================================
  // Helpers
  function automatic logic addr_hit(input logic [7:0] b, input logic lsb);
    addr_hit = (b[7:2] == ADDR_PREFIX) && (b[1] == lsb);
  endfunction

  // Bit to send: word high byte first, each byte MSB first
  function automatic logic tx_bit(input logic [15:0] w, input logic hi,
                                  input logic [3:0] cnt);
    logic [7:0] b;
    b      = hi ? w[15:8] : w[7:0];
    tx_bit = b[3'(4'h7 - cnt)];
  endfunction

  // ========================================================================
  // Protocol state
  dd_state_t   state;
  dd_state_t   next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic        rw;
  logic        next_rw;
  logic [7:0]  pointer;
  logic [7:0]  next_pointer;
  logic        hi_half;
  logic        next_hi_half;
  logic [7:0]  hi_byte;
  logic [7:0]  next_hi_byte;
  logic [15:0] tx_word;
  logic [15:0] next_tx_word;
  logic [15:0] rd_word;
  logic        next_sda_oe;
  logic        commit;
  logic        next_commit;
  dd_word_t    commit_word;
  dd_word_t    next_commit_word;
  dd_word_t    word_a;
  dd_word_t    word_b;

  // Readback picks one channel; none or both give READ_DEFAULT, zeros with clear bit one
  always_comb begin
    if (pointer[PTR_SEL_B_BIT:PTR_SEL_A_BIT] == 2'h1) begin
      rd_word = word_a;
    end else if (pointer[PTR_SEL_B_BIT:PTR_SEL_A_BIT] == 2'h2) begin
      rd_word = word_b;
    end else begin
      rd_word = READ_DEFAULT;
    end
  end

  // Next-state logic of the serial engine
  always_comb begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_shreg       = shreg;
    next_rw          = rw;
    next_pointer     = pointer;
    next_hi_half     = hi_half;
    next_hi_byte     = hi_byte;
    next_tx_word     = tx_word;
    next_sda_oe      = sda_oe;
    next_commit      = 1'b0;
    next_commit_word = commit_word;
    if (start_det) begin
      next_state   = ST_ADDR;
      next_bit_cnt = CNT_RESET;
      next_sda_oe  = 1'b0;
    end else if (stop_det) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_PTR, ST_DATA: begin
          if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            next_bit_cnt = CNT_RESET;
            next_sda_oe  = 1'b1;
            if (state == ST_ADDR) begin
              if (addr_hit(shreg, addr_sel_s)) begin
                next_rw    = shreg[0];
                next_state = ST_ADDR_ACK;
              end else begin
                next_sda_oe = 1'b0;
                next_state  = ST_IDLE;
              end
            end else if (state == ST_PTR) begin
              next_pointer = shreg;
              next_hi_half = 1'b1;
              next_state   = ST_PTR_ACK;
            end else begin
              // Two bytes make one word
              next_state = ST_DATA_ACK;
              if (hi_half) begin
                next_hi_byte = shreg;
              end else begin
                next_commit      = 1'b1;
                next_commit_word = {hi_byte, shreg};
              end
              next_hi_half = !hi_half;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              // Read uses whatever pointer is retained
              next_tx_word = rd_word;
              next_hi_half = 1'b1;
              next_sda_oe  = !tx_bit(rd_word, 1'b1, CNT_RESET);
              next_state   = ST_SEND;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state  = ST_DATA;
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_state  = ST_SEND_ACK;
            end else begin
              next_sda_oe = !tx_bit(tx_word, hi_half, bit_cnt);
            end
          end
        end
        ST_SEND_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              next_state = ST_IDLE;
            end else begin
              // Acknowledged: next byte, repeating the word endlessly
              next_hi_half = !hi_half;
              next_bit_cnt = CNT_RESET;
              next_state   = ST_SEND;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Registers of the serial engine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      bit_cnt     <= CNT_RESET;
      shreg       <= 8'h00;
      rw          <= 1'b0;
      pointer     <= PTR_RESET;
      hi_half     <= 1'b1;
      hi_byte     <= 8'h00;
      tx_word     <= WORD_RESET;
      sda_oe      <= 1'b0;
      sda_out     <= 1'b0;
      commit      <= 1'b0;
      commit_word <= WORD_RESET;
    end else begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      shreg       <= next_shreg;
      rw          <= next_rw;
      pointer     <= next_pointer;
      hi_half     <= next_hi_half;
      hi_byte     <= next_hi_byte;
      tx_word     <= next_tx_word;
      sda_oe      <= next_sda_oe;
      sda_out     <= 1'b0; // Open drain: only ever pulls low
      commit      <= next_commit;
      commit_word <= next_commit_word;
    end
  end

  // ========================================================================
  // Channels, A on pointer bit 0 and B on bit 1
  logic     [1:0]          sel_bits;
  logic     [RES_BITS-1:0] codes   [2];
  logic     [1:0]          pds     [2];
  dd_word_t                rwords  [2];

  assign sel_bits = pointer[PTR_SEL_B_BIT:PTR_SEL_A_BIT];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dd_chan #(.RES_BITS(RES_BITS)) u_chan (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .commit   (commit),
      .sel      (sel_bits[ch]),
      .word     (commit_word),
      .dac_code (codes[ch]),
      .pd_mode  (pds[ch]),
      .rd_word  (rwords[ch])
    );
  end

  assign code_a      = codes[0];
  assign code_b      = codes[1];
  assign powerdown_a = pds[0];
  assign powerdown_b = pds[1];
  assign word_a      = rwords[0];
  assign word_b      = rwords[1];

  // ========================================================================
  // Checks
  AST_ADDR_ACK: assert property (
    @(posedge clock) disable iff (sys_rst)
    state == ST_ADDR && scl_fall && bit_cnt == BITS_PER_BYTE && !start_det
      && !stop_det && addr_hit(shreg, addr_sel_s) |=> sda_oe && state == ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  AST_ADDR_MISS: assert property (
    @(posedge clock) disable iff (sys_rst)
    state == ST_ADDR && scl_fall && bit_cnt == BITS_PER_BYTE && !start_det
      && !stop_det && !addr_hit(shreg, addr_sel_s) |=> !sda_oe && state == ST_IDLE)
    else $error("foreign address acknowledged");
  AST_SDA_LOW_ONLY: assert property (
    @(posedge clock) disable iff (sys_rst)
    $changed(sda_oe) && !$past(start_det) && !$past(stop_det) |-> !$past(scl_s))
    else $error("sda changed while scl high");
  AST_START: assert property (
    @(posedge clock) disable iff (sys_rst)
    start_det |=> state == ST_ADDR && bit_cnt == CNT_RESET && !sda_oe)
    else $error("start not recognised");
  AST_PTR_STORE: assert property (
    @(posedge clock) disable iff (sys_rst)
    state == ST_PTR && scl_fall && bit_cnt == BITS_PER_BYTE && !start_det
      && !stop_det |=> pointer == $past(shreg) ##1 state == ST_PTR_ACK)
    else $error("pointer not stored");
  AST_READ_DEFAULT: assert property (
    @(posedge clock) disable iff (sys_rst)
    state == ST_SEND && sel_bits != 2'h1 && sel_bits != 2'h2
      && $past(state) == ST_ADDR_ACK |-> tx_word == READ_DEFAULT)
    else $error("default readback pattern wrong");
  AST_ACK_RELEASE: assert property (
    @(posedge clock) disable iff (sys_rst)
    state == ST_DATA_ACK && scl_fall && !start_det && !stop_det
      |=> !sda_oe && state == ST_DATA && bit_cnt == CNT_RESET)
    else $error("ack not released after ninth clock");
  AST_NACK_END: assert property (
    @(posedge clock) disable iff (sys_rst)
    state == ST_SEND_ACK && scl_rise && sda_s && !start_det && !stop_det
      |=> state == ST_IDLE [*2])
    else $error("not-acknowledge did not end read");

endmodule

// *** dd_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dd_sync import dd_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // ========================================================================
  // First stage feeds only the second stage
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  // Shift through both stages
  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  // Idle bus is high, so reset both stages high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule

// *** test_dual_dac_two_wire_slave.sv ***
// Self-checking bench of the two-wire slave against a reference model
`timescale 1ns/1ps
module test_dual_dac_two_wire_slave import dd_pkg::*;;
  logic        clock;
  logic        sys_rst;
  logic        addr_sel;
  logic        sda_out;
  logic        sda_oe;
  logic        scl_line;
  logic        sda_pull;
  wire  logic  sda_wire;
  logic [11:0] code_a;
  logic [11:0] code_b;
  logic [1:0]  powerdown_a;
  logic [1:0]  powerdown_b;
  int          fails;
  int          checks_done;
  int          cycles;
  integer      seed;
  // Reference model: readback words, converter codes, modes, pointer
  logic [15:0] rd_m [2];
  logic [11:0] dac_m [2];
  logic [1:0]  pd_m [2];
  bit          dirty [2];
  logic [7:0]  ptr_m;

  // ==========================================================
  // Clock, open-drain wire with pull-up, and the parties
  initial clock = 1'b0;
  always #5 clock = ~clock;
  assign sda_wire = ~(sda_oe | sda_pull);

  dd_slave #(.RES_BITS(12)) u_dd_slave (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl_line), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(addr_sel),
    .code_a(code_a), .code_b(code_b),
    .powerdown_a(powerdown_a), .powerdown_b(powerdown_b)
  );
  dd_master u_dd_master (
    .clock(clock), .sda_wire(sda_wire), .scl_line(scl_line), .sda_pull(sda_pull)
  );

  // ==========================================================
  // Reporting
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard: whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check_outs();
    check({4'h0, code_a}, {4'h0, dac_m[0]});
    check({4'h0, code_b}, {4'h0, dac_m[1]});
    check({14'h0, powerdown_a}, {14'h0, pd_m[0]});
    check({14'h0, powerdown_b}, {14'h0, pd_m[1]});
    check({15'h0, sda_out}, 16'h0000);
  endtask

  // Model of one committed word; clear wins over load and leaves modes alone
  task automatic model_word(input logic [15:0] w);
    for (int c = 0; c < 2; c++) begin
      if (ptr_m[c] && w[13]) begin
        rd_m[c] = w;
        pd_m[c] = w[15:14];
        dirty[c] = 1'b1;
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (!w[13]) begin
        rd_m[c] = 16'h0000;
        dac_m[c] = 12'h000;
        dirty[c] = 1'b0;
      end else if (!w[12] && dirty[c]) begin
        dac_m[c] = rd_m[c][11:0];
        dirty[c] = 1'b0;
      end
    end
  endtask

  // Write: address, pointer, two data bytes, all acknowledged
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w);
    logic       ack;
    logic [7:0] b [4];
    b = '{{ADDR_PREFIX, addr_sel, 1'b0}, ptr, w[15:8], w[7:0]};
    u_dd_master.start(1'b0);
    foreach (b[i]) begin
      u_dd_master.wbyte(b[i], ack);
      check({15'h0, ack}, 16'h0001);
    end
    u_dd_master.stop();
    ptr_m = ptr;
    model_word(w);
    check_outs();
  endtask

  // Read, optionally setting the pointer first; several words in a row
  task automatic rd(input logic with_ptr, input logic [7:0] ptr, input int words);
    logic        ack;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [15:0] exp;
    if (with_ptr) begin
      u_dd_master.start(1'b0);
      u_dd_master.wbyte({ADDR_PREFIX, addr_sel, 1'b0}, ack);
      check({15'h0, ack}, 16'h0001);
      u_dd_master.wbyte(ptr, ack);
      check({15'h0, ack}, 16'h0001);
      ptr_m = ptr;
    end
    u_dd_master.start(with_ptr);
    u_dd_master.wbyte({ADDR_PREFIX, addr_sel, 1'b1}, ack);
    check({15'h0, ack}, 16'h0001);
    exp = (ptr_m[1:0] == 2'b01) ? rd_m[0] : (ptr_m[1:0] == 2'b10) ? rd_m[1] : 16'h2000;
    for (int k = 0; k < words; k++) begin
      u_dd_master.rbyte(1'b1, hi);
      u_dd_master.rbyte(k < words - 1, lo);
      check({hi, lo}, exp);
    end
    u_dd_master.stop();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic        ack;
    logic [31:0] r;
    logic [7:0]  bad [2];
    sys_rst = 1'b1;
    addr_sel = 1'b0;
    seed = 32'h08ece539;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    ptr_m = 8'h00;
    rd_m = '{16'h0000, 16'h0000};
    dac_m = '{12'h000, 12'h000};
    pd_m = '{2'h0, 2'h0};
    dirty = '{1'b0, 1'b0};
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    check({15'h0, sda_oe}, 16'h0000);
    check_outs();
    rd(1'b0, 8'h00, 1);
    for (int p = 0; p < 2; p++) begin
      addr_sel <= p[0];
      repeat (4) @(posedge clock);
      // Foreign addresses get no ack and the slave stays off the wire
      bad = '{{ADDR_PREFIX, ~addr_sel, 1'b0}, {6'h07, addr_sel, 1'b0}};
      foreach (bad[i]) begin
        u_dd_master.start(1'b0);
        u_dd_master.wbyte(bad[i], ack);
        check({15'h0, ack}, 16'h0000);
        u_dd_master.wbyte(8'h03, ack);
        check({15'h0, ack}, 16'h0000);
        u_dd_master.stop();
      end
      // Every mode with channel A, B and both selected, random codes and load bits
      for (int i = 0; i < 12; i++) begin
        r = $random(seed);
        wr({r[31:30], 4'h0, 2'(i % 3 + 1)}, {2'(i % 4), 1'b1, r[12], r[11:0]});
        rd(1'b1, {2'h0, 4'h0, 2'(i % 3 + 1)}, 2);
        rd(1'b0, 8'h00, 1);
      end
    end
    // Clear zeroes both channels even with load held off
    wr(8'h01, 16'h1abc);
    rd(1'b1, 8'h02, 1);
    rd(1'b1, 8'h00, 1);
    stop_test();
  end
endmodule
